/* hdl/tx_sync_status_interrupts.sv */
// Purpose: Transmit synchronizer control, latched status and interrupt
// Assumes: Framer event inputs are one-cycle pulses on clk
// Notes:   Transmit clock pin is sampled, not used as a clock
//
// What this block does
// - In E1, CRC-4 multiframe search runs only while its control bit is one
// - Synchronizer operates only while its enable bit is one
// - Inhibit bit zero allows automatic resync, one blocks it
// - Each zero-to-one write of resync bit starts one resync if the same write sets the enable bit
// - Latch full or empty by slip type, and slip on either elastic store slip
// - In T1, when enabled, latch long multiframe flag each 72 frames
// - In T1, latch pulse density violation flag
// - In E1, status bit 3 latches the align frame flag instead
// - Latch multiframe flag on each transmit multiframe boundary
// - Latch clock loss after about three silent transmit clock periods
// - Latch clock restored when transmit clock toggles again
// - Live clock loss stays high while clock absent, despite clearing
// - Unmasked clock loss drives interrupt low; releases when none pending
// - In T1, latch data link empty when all eight bits shifted
// - FIFO empty before message end latches underrun and sends abort
// - Latch message end when HDLC finishes a message
// - Latch on rising edge of FIFO below selected low watermark
// - Latch on rising edge of FIFO not full
// - Show live frame hunt and latch it when hunting, both only while the enable bit is one
// - Summary shows a live pending bit per status register
// - Each main status bit interrupts when its mask bit is one
// - Two-bit field selects watermark 4, 16, 32 or 48 bytes

`timescale 1ns/1ps

module tx_sync_status_interrupts
	import tx_status_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        ce,
	// Register port
	input  wire logic [11:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// Mode
	input  wire logic        t1_mode,
	input  wire logic        long_mf_enable,
	// Framer events
	input  wire logic        es_full_evt,
	input  wire logic        es_empty_evt,
	input  wire logic        long_mf_evt,
	input  wire logic        pdv_evt,
	input  wire logic        align_evt,
	input  wire logic        mf_evt,
	// Transmit clock pin
	input  wire logic        transmit_clock_input,
	output logic             clock_loss_live,
	// HDLC and data link
	input  wire logic [6:0]  fifo_level,
	input  wire logic        fifo_drained_evt,
	input  wire logic        msg_end_marked,
	input  wire logic        msg_end_evt,
	input  wire logic        fdl_shift_done,
	output logic             abort_send,
	// Synchronizer
	input  wire logic        frame_hunt_live,
	output logic             sync_enable,
	output logic             crc4_search,
	output logic             auto_resync_allow,
	output logic             resync_start,
	// Interrupt
	output logic             interrupt_out_n
);

	// ==========================================================
	// Register decode
	logic       wr_ctrl;
	logic       wr_fifo;
	logic       wr_main;
	logic       wr_hdlc;
	logic       wr_sync;
	logic       wr_mask;
	logic [7:0] main_clr;
	logic [7:0] hdlc_clr;
	logic [7:0] sync_clr;

	assign wr_ctrl  = reg_wr && (reg_addr == OFS_SYNC_CTRL);
	assign wr_fifo  = reg_wr && (reg_addr == OFS_FIFO_CTRL);
	assign wr_main  = reg_wr && (reg_addr == OFS_MAIN_LS);
	assign wr_hdlc  = reg_wr && (reg_addr == OFS_HDLC_LS);
	assign wr_sync  = reg_wr && (reg_addr == OFS_SYNC_LS);
	assign wr_mask  = reg_wr && (reg_addr == OFS_MAIN_MASK);
	assign main_clr = wr_main ? reg_wdata : 8'h00;
	assign hdlc_clr = wr_hdlc ? (reg_wdata & HDLC_LS_USED) : 8'h00;
	assign sync_clr = wr_sync ? (reg_wdata & SYNC_LS_W1C) : 8'h00;

	// ==========================================================
	// Control registers
	logic [7:0] ctrl_r;
	logic [7:0] fifo_ctrl_r;
	logic [7:0] mask_r;
	logic       sync_en;

	assign sync_en = ctrl_r[SC_ENABLE];

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctrl_r      <= RST_VAL;
			fifo_ctrl_r <= RST_VAL;
			mask_r      <= RST_VAL;
		end
		else if (ce)
		begin
			if (wr_ctrl)
				ctrl_r <= reg_wdata & SYNC_CTRL_WMASK;
			if (wr_fifo)
				fifo_ctrl_r <= reg_wdata & FIFO_CTRL_WMASK;
			if (wr_mask)
				mask_r <= reg_wdata;
		end
	end

	// ==========================================================
	// Transmit clock loss detector
	// Pin passes two flops; a third only feeds the edge compare.
	logic       pin_s1_r;
	logic       pin_s2_r;
	logic       pin_s3_r;
	logic [8:0] loss_cnt_r;
	logic       loss_r;
	logic       pin_edge;
	logic       loss_hit;

	assign pin_edge  = pin_s2_r ^ pin_s3_r;
	assign loss_hit  = !loss_r && !pin_edge &&
		(loss_cnt_r == 9'(LOSS_CYCLES - 1));

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pin_s1_r   <= 1'b0;
			pin_s2_r   <= 1'b0;
			pin_s3_r   <= 1'b0;
			loss_cnt_r <= 9'h000;
			loss_r     <= 1'b0;
		end
		else if (ce)
		begin
			pin_s1_r <= transmit_clock_input;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			if (pin_edge)
			begin
				loss_cnt_r <= 9'h000;
				loss_r     <= 1'b0;
			end
			else if (loss_hit)
				loss_r <= 1'b1;
			else if (!loss_r)
				loss_cnt_r <= loss_cnt_r + 9'h001;
		end
	end

	assign clock_loss_live = loss_r;

	// ==========================================================
	// Main status sources
	logic [7:0] main_set;
	logic [7:0] main_r;

	assign main_set[MS_FULL]    = es_full_evt;
	assign main_set[MS_EMPTY]   = es_empty_evt;
	assign main_set[MS_SLIP]    = es_full_evt || es_empty_evt;
	assign main_set[MS_LONG_MF] = t1_mode && long_mf_enable &&
		long_mf_evt;
	assign main_set[MS_PDV_AF]  = t1_mode ? pdv_evt :
		align_evt;
	assign main_set[MS_MF]      = mf_evt;
	assign main_set[MS_RESTORE] = loss_r && pin_edge;
	assign main_set[MS_LOSS]    = loss_hit;

	// ==========================================================
	// HDLC status sources
	logic       below_wm;
	logic       below_wm_prev_r;
	logic       not_full;
	logic       not_full_prev_r;
	logic [6:0] wm_level;
	logic       underrun;
	logic [7:0] hdlc_set;
	logic [7:0] hdlc_r;

	assign wm_level = (fifo_ctrl_r[1:0] == 2'h0) ? WM_SEL0 :
		(fifo_ctrl_r[1:0] == 2'h1) ? WM_SEL1 :
		(fifo_ctrl_r[1:0] == 2'h2) ? WM_SEL2 : WM_SEL3;
	assign below_wm = fifo_level < wm_level;
	assign not_full = fifo_level < FIFO_DEPTH;
	assign underrun = fifo_drained_evt && !msg_end_marked;

	assign hdlc_set[7:5]    = 3'h0;
	assign hdlc_set[HS_FDL]  = t1_mode && fdl_shift_done;
	assign hdlc_set[HS_UDR]  = underrun;
	assign hdlc_set[HS_MEND] = msg_end_evt;
	assign hdlc_set[HS_LWM]  = below_wm && !below_wm_prev_r;
	assign hdlc_set[HS_NF]   = not_full && !not_full_prev_r;

	// ==========================================================
	// Synchronizer status and control outputs
	logic [7:0] sync_set;
	logic [7:0] sync_r;
	logic       hunt_live;

	assign hunt_live = frame_hunt_live && sync_en;
	assign sync_set  = {7'h00, hunt_live};

	// ==========================================================
	// Latched status: set wins over a same-cycle clear
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			main_r          <= RST_VAL;
			hdlc_r          <= RST_VAL;
			sync_r          <= RST_VAL;
			below_wm_prev_r <= 1'b0;
			not_full_prev_r <= 1'b0;
		end
		else if (ce)
		begin
			main_r          <= (main_r & ~main_clr) | main_set;
			hdlc_r          <= (hdlc_r & ~hdlc_clr) | hdlc_set;
			sync_r          <= (sync_r & ~sync_clr) | sync_set;
			below_wm_prev_r <= below_wm;
			not_full_prev_r <= not_full;
		end
	end

	// ==========================================================
	// Summary and interrupt
	logic [7:0] summary;

	assign summary = {5'h00, sync_r[SS_LATCH], |hdlc_r,
		|(main_r & mask_r)};

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			interrupt_out_n   <= 1'b1;
			abort_send        <= 1'b0;
			resync_start      <= 1'b0;
			sync_enable       <= 1'b0;
			crc4_search       <= 1'b0;
			auto_resync_allow <= 1'b0;
		end
		else if (ce)
		begin
			interrupt_out_n   <= ~|summary;
			abort_send        <= underrun;
			resync_start      <= wr_ctrl && reg_wdata[SC_RESYNC] &&
				!ctrl_r[SC_RESYNC] && reg_wdata[SC_ENABLE];
			sync_enable       <= sync_en;
			crc4_search       <= ctrl_r[SC_CRC4] && sync_en &&
				!t1_mode;
			auto_resync_allow <= !ctrl_r[SC_INHIBIT] && sync_en;
		end
	end

	// ==========================================================
	// Read data, one cycle after the read strobe
	logic [7:0] rd_mux;
	logic [7:0] sync_view;

	assign sync_view = {6'h00, hunt_live, sync_r[SS_LATCH]};
	assign rd_mux =
		(reg_addr == OFS_SYNC_CTRL) ? ctrl_r      :
		(reg_addr == OFS_FIFO_CTRL) ? fifo_ctrl_r :
		(reg_addr == OFS_MAIN_LS)   ? main_r      :
		(reg_addr == OFS_HDLC_LS)   ? hdlc_r      :
		(reg_addr == OFS_SYNC_LS)   ? sync_view   :
		(reg_addr == OFS_SUMMARY)   ? summary     :
		(reg_addr == OFS_MAIN_MASK) ? mask_r      : 8'h00;

	always_ff @(posedge clk)
	begin
		if (srst)
			reg_rdata <= 8'h00;
		else if (ce && reg_rd)
			reg_rdata <= rd_mux;
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	chk_crc4_gate: assert property (
		ce |=> crc4_search ==
			$past(ctrl_r[SC_CRC4] && sync_en && !t1_mode))
		else $error("crc4 search not gated by mode and enable");

	chk_inhibit_sense: assert property (
		ce && ctrl_r[SC_INHIBIT] |=> !auto_resync_allow)
		else $error("auto resync allowed while inhibited");

	chk_resync_pulse: assert property (
		ce && wr_ctrl && reg_wdata[SC_RESYNC] && reg_wdata[SC_ENABLE]
		&& !ctrl_r[SC_RESYNC] |=> resync_start ##1 !resync_start)
		else $error("resync pulse missing or too long");

	chk_slip_latch: assert property (
		ce && es_full_evt |=> main_r[MS_FULL] && main_r[MS_SLIP])
		else $error("full event did not latch full and slip");

	chk_set_wins: assert property (
		ce && mf_evt && wr_main && reg_wdata[MS_MF] |=> main_r[MS_MF])
		else $error("multiframe event lost to clear");

	chk_loss_latch: assert property (
		ce && loss_hit |=> clock_loss_live && main_r[MS_LOSS])
		else $error("clock loss not latched");

	chk_restore_latch: assert property (
		ce && loss_r && pin_edge |=> !clock_loss_live &&
			main_r[MS_RESTORE])
		else $error("clock restore not latched");

	chk_loss_persists: assert property (
		ce && loss_r && !pin_edge |=> clock_loss_live)
		else $error("live clock loss dropped without clock");

	chk_int_assert: assert property (
		ce && main_r[MS_LOSS] && mask_r[MS_LOSS] |=> !interrupt_out_n)
		else $error("unmasked clock loss did not interrupt");

	chk_int_release: assert property (
		ce && summary == 8'h00 |=> interrupt_out_n)
		else $error("interrupt held with nothing pending");

	chk_underrun_abort: assert property (
		ce && underrun |=> abort_send && hdlc_r[HS_UDR])
		else $error("underrun without abort or flag");

	chk_watermark_edge: assert property (
		ce && below_wm && !below_wm_prev_r |=> hdlc_r[HS_LWM])
		else $error("watermark edge not latched");

	chk_hunt_latch: assert property (
		ce && frame_hunt_live && sync_en |=> sync_r[SS_LATCH])
		else $error("frame hunt not latched");

	chk_w1c_hold: assert property (
		ce && main_r[MS_MF] && !(wr_main && reg_wdata[MS_MF])
		|=> main_r[MS_MF])
		else $error("latched bit lost without clear");

	cov_loss_restore: cover property (
		loss_hit ##[1:1000] (loss_r && pin_edge));
	cov_resync: cover property (resync_start);
	cov_underrun: cover property (abort_send);
	cov_interrupt: cover property (!interrupt_out_n ##1 interrupt_out_n);

endmodule

/* pkg/tx_status_pkg.sv */
// Purpose: Shared constants for the transmit status and interrupt block
// Assumes: 8-bit register port, 12-bit register addresses
// Notes:   Offsets are byte addresses on the register port

package tx_status_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [11:0] OFS_FIFO_CTRL = 12'h187;
	localparam logic [11:0] OFS_SYNC_CTRL = 12'h18e;
	localparam logic [11:0] OFS_MAIN_LS   = 12'h190;
	localparam logic [11:0] OFS_HDLC_LS   = 12'h191;
	localparam logic [11:0] OFS_SYNC_LS   = 12'h192;
	localparam logic [11:0] OFS_SUMMARY   = 12'h19f;
	localparam logic [11:0] OFS_MAIN_MASK = 12'h1a0;

	// ==========================================================
	// Reset values and writable bits
	localparam logic [7:0] RST_VAL         = 8'h00;
	localparam logic [7:0] SYNC_CTRL_WMASK = 8'h0f;
	localparam logic [7:0] FIFO_CTRL_WMASK = 8'h03;
	localparam logic [7:0] HDLC_LS_USED    = 8'h1f;
	localparam logic [7:0] SYNC_LS_W1C     = 8'h01;

	// ==========================================================
	// Field positions
	localparam int SC_CRC4    = 3;
	localparam int SC_ENABLE  = 2;
	localparam int SC_INHIBIT = 1;
	localparam int SC_RESYNC  = 0;
	localparam int MS_FULL    = 7;
	localparam int MS_EMPTY   = 6;
	localparam int MS_SLIP    = 5;
	localparam int MS_LONG_MF = 4;
	localparam int MS_PDV_AF  = 3;
	localparam int MS_MF      = 2;
	localparam int MS_RESTORE = 1;
	localparam int MS_LOSS    = 0;
	localparam int HS_FDL     = 4;
	localparam int HS_UDR     = 3;
	localparam int HS_MEND    = 2;
	localparam int HS_LWM     = 1;
	localparam int HS_NF      = 0;
	localparam int SS_LIVE    = 1;
	localparam int SS_LATCH   = 0;

	// ==========================================================
	// FIFO watermarks, in bytes
	localparam logic [6:0] FIFO_DEPTH = 7'h40;
	localparam logic [6:0] WM_SEL0    = 7'h04;
	localparam logic [6:0] WM_SEL1    = 7'h10;
	localparam logic [6:0] WM_SEL2    = 7'h20;
	localparam logic [6:0] WM_SEL3    = 7'h30;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS  = 4;
	localparam int PIN_PERIOD_NS  = 648;
	localparam int LOSS_PERIODS   = 3;
	localparam int LOSS_CYCLES    =
		(PIN_PERIOD_NS * LOSS_PERIODS) / CLK_PERIOD_NS;

endpackage

/* tb/tx_host_model.sv */
// Purpose: Host processor model on the register port
// Assumes: Strobes change on the falling clock edge, one cycle each
// Notes:   Released address and data show the inverse of the last value

`timescale 1ns/1ps

module tx_host_model
(
	// Clock
	input  wire logic        clk,
	// Register port
	output logic      [11:0] reg_addr,
	output logic             reg_wr,
	output logic             reg_rd,
	output logic      [7:0]  reg_wdata,
	input  wire logic [7:0]  reg_rdata
);
	// ==========================================================
	// Idle bus
	initial
	begin
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// ==========================================================
	// Bus cycles
	// Status clears by writing ones, so a zero write is also a probe
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
	begin
		@(negedge clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	end
	endtask

	task automatic rd(input logic [11:0] a, output logic [7:0] d);
	begin
		@(negedge clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		reg_addr = ~a;
		d = reg_rdata;
	end
	endtask
endmodule

/* tb/tx_sync_status_interrupts_bench.sv */
// Purpose: Self-checking bench for transmit status and interrupt logic
// Assumes: Inputs change on the falling clock edge
// Notes:   Clock enable is tied high; freezing is not exercised

`timescale 1ns/1ps

module tx_sync_status_interrupts_bench
	import tx_status_pkg::*;
;
	// ==========================================================
	// Signals
	logic        clk, srst, t1_mode, long_mf_enable, tx_clk_pin, tx_clk_run;
	logic        es_full_evt, es_empty_evt, long_mf_evt, pdv_evt;
	logic        align_evt, mf_evt, fifo_drained_evt, msg_end_marked;
	logic        msg_end_evt, fdl_shift_done, frame_hunt_live;
	logic        reg_wr, reg_rd, clock_loss_live, abort_send;
	logic        sync_enable, crc4_search, auto_resync_allow;
	logic        resync_start, interrupt_out_n;
	logic [6:0]  fifo_level;
	logic [11:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata, rd_val;
	int          num_errors, cmp_count, cycles, rs_cnt, ab_cnt;

	typedef struct packed {
		logic        t1;
		logic        lmf;
		logic        mk;
		logic [8:0]  ev;
		logic [11:0] a;
		logic [7:0]  x;
	} row_t;

	// Event bits: fdl, msg end, drained, full, empty, long, pdv, align, mf
	row_t        rows [14] = '{
		'{1'b0, 1'b0, 1'b0, 9'h020, OFS_MAIN_LS, 8'ha0},
		'{1'b0, 1'b0, 1'b0, 9'h010, OFS_MAIN_LS, 8'h60},
		'{1'b1, 1'b1, 1'b0, 9'h008, OFS_MAIN_LS, 8'h10},
		'{1'b1, 1'b0, 1'b0, 9'h008, OFS_MAIN_LS, 8'h00},
		'{1'b1, 1'b0, 1'b0, 9'h004, OFS_MAIN_LS, 8'h08},
		'{1'b0, 1'b0, 1'b0, 9'h002, OFS_MAIN_LS, 8'h08},
		'{1'b1, 1'b0, 1'b0, 9'h002, OFS_MAIN_LS, 8'h00},
		'{1'b0, 1'b0, 1'b0, 9'h004, OFS_MAIN_LS, 8'h00},
		'{1'b1, 1'b0, 1'b0, 9'h001, OFS_MAIN_LS, 8'h04},
		'{1'b0, 1'b0, 1'b0, 9'h001, OFS_MAIN_LS, 8'h04},
		'{1'b0, 1'b0, 1'b0, 9'h040, OFS_HDLC_LS, 8'h08},
		'{1'b0, 1'b0, 1'b1, 9'h040, OFS_HDLC_LS, 8'h00},
		'{1'b0, 1'b0, 1'b0, 9'h080, OFS_HDLC_LS, 8'h04},
		'{1'b1, 1'b0, 1'b0, 9'h100, OFS_HDLC_LS, 8'h10}};
	// Control value, mode, then enable, search, auto resync expected
	logic [11:0] sc [4] = '{{8'h0c, 4'b0111}, {8'h0c, 4'b1101},
		{8'h06, 4'b0100}, {8'h08, 4'b0000}};
	logic [6:0]  wm [4] = '{WM_SEL0, WM_SEL1, WM_SEL2, WM_SEL3};
	logic [11:0] rst_addr [8] = '{OFS_MAIN_LS, OFS_HDLC_LS, OFS_SYNC_LS,
		OFS_SUMMARY, OFS_MAIN_MASK, OFS_SYNC_CTRL, OFS_FIFO_CTRL, 12'h1ff};

	// ==========================================================
	// Instances
	tx_sync_status_interrupts i_tx_sync_status_interrupts (
		.clk(clk), .srst(srst), .ce(1'b1), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .t1_mode(t1_mode),
		.long_mf_enable(long_mf_enable), .es_full_evt(es_full_evt),
		.es_empty_evt(es_empty_evt), .long_mf_evt(long_mf_evt),
		.pdv_evt(pdv_evt), .align_evt(align_evt), .mf_evt(mf_evt),
		.transmit_clock_input(tx_clk_pin), .clock_loss_live(clock_loss_live),
		.fifo_level(fifo_level), .fifo_drained_evt(fifo_drained_evt),
		.msg_end_marked(msg_end_marked), .msg_end_evt(msg_end_evt),
		.fdl_shift_done(fdl_shift_done), .abort_send(abort_send),
		.frame_hunt_live(frame_hunt_live), .sync_enable(sync_enable),
		.crc4_search(crc4_search), .auto_resync_allow(auto_resync_allow),
		.resync_start(resync_start), .interrupt_out_n(interrupt_out_n));

	tx_host_model i_tx_host_model (
		.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

	// ==========================================================
	// Clocks, pulse counters, timeout
	always #2 clk = ~clk;
	// Transmit clock toggles on falling clk edges and stops on demand
	always #(PIN_PERIOD_NS / 2) if (tx_clk_run) tx_clk_pin = ~tx_clk_pin;

	always @(posedge clk)
	begin
		cycles++;
		rs_cnt += (resync_start === 1'b1);
		ab_cnt += (abort_send === 1'b1);
		if (cycles == 20000)
		begin
			num_errors++;
			$display("MISMATCH %0t timeout", $time);
			wrap_up();
		end
	end

	// ==========================================================
	// Compares and report
	task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t reg got %h exp %h", $time, got, exp);
		end
	end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
	begin
		cmp_count++;
		if (got !== exp)
		begin
			num_errors++;
			$display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
		end
	end
	endtask

	task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
	begin
		i_tx_host_model.rd(a, rd_val);
		chk_reg(rd_val, exp);
	end
	endtask

	task automatic wrap_up;
	begin
		$display("Errors %0d, compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		{clk, t1_mode, long_mf_enable, msg_end_marked, frame_hunt_live} = 0;
		{fdl_shift_done, msg_end_evt, fifo_drained_evt, es_full_evt,
			es_empty_evt, long_mf_evt, pdv_evt, align_evt, mf_evt} = 9'h000;
		{num_errors, cmp_count, cycles, rs_cnt, ab_cnt} = 0;
		// Full FIFO at start so no watermark edge appears early
		fifo_level = FIFO_DEPTH;
		tx_clk_pin = 1'b0;
		tx_clk_run = 1'b1;
		srst = 1'b1;
		repeat (16) @(negedge clk);
		srst = 1'b0;
		foreach (rst_addr[i])
			rdc(rst_addr[i], RST_VAL);
		chk_bit(interrupt_out_n, 1'b1);

		foreach (rows[i])
		begin
			t1_mode = rows[i].t1;
			long_mf_enable = rows[i].lmf;
			msg_end_marked = rows[i].mk;
			@(negedge clk);
			{fdl_shift_done, msg_end_evt, fifo_drained_evt, es_full_evt,
				es_empty_evt, long_mf_evt, pdv_evt, align_evt,
				mf_evt} = rows[i].ev;
			@(negedge clk);
			{fdl_shift_done, msg_end_evt, fifo_drained_evt, es_full_evt,
				es_empty_evt, long_mf_evt, pdv_evt, align_evt,
				mf_evt} = 9'h000;
			rdc(rows[i].a, rows[i].x);
			i_tx_host_model.wr(rows[i].a, 8'hff);
		end
		chk_reg(8'(ab_cnt), 8'h01);

		// Clock loss with its mask bit on, cleared while still lost
		t1_mode = 1'b0;
		i_tx_host_model.wr(OFS_MAIN_MASK, 8'h01);
		rdc(OFS_MAIN_MASK, 8'h01);
		tx_clk_run = 1'b0;
		repeat (LOSS_CYCLES + 20) @(negedge clk);
		chk_bit(clock_loss_live, 1'b1);
		rdc(OFS_MAIN_LS, 8'h01);
		chk_bit(interrupt_out_n, 1'b0);
		rdc(OFS_SUMMARY, 8'h01);
		i_tx_host_model.wr(OFS_MAIN_LS, 8'h00);
		rdc(OFS_MAIN_LS, 8'h01);
		i_tx_host_model.wr(OFS_MAIN_LS, 8'h01);
		repeat (3) @(negedge clk);
		rdc(OFS_MAIN_LS, 8'h00);
		chk_bit(clock_loss_live, 1'b1);
		chk_bit(interrupt_out_n, 1'b1);
		rdc(OFS_SUMMARY, 8'h00);
		tx_clk_run = 1'b1;
		repeat (400) @(negedge clk);
		chk_bit(clock_loss_live, 1'b0);
		rdc(OFS_MAIN_LS, 8'h02);
		chk_bit(interrupt_out_n, 1'b1);
		i_tx_host_model.wr(OFS_MAIN_LS, 8'h02);

		// Synchronizer control bits against mode
		foreach (sc[i])
		begin
			t1_mode = sc[i][3];
			i_tx_host_model.wr(OFS_SYNC_CTRL, sc[i][11:4]);
			repeat (2) @(negedge clk);
			chk_bit(sync_enable, sc[i][2]);
			chk_bit(crc4_search, sc[i][1]);
			chk_bit(auto_resync_allow, sc[i][0]);
		end
		// A repeated one starts nothing; zero then one starts again
		i_tx_host_model.wr(OFS_SYNC_CTRL, 8'h05);
		i_tx_host_model.wr(OFS_SYNC_CTRL, 8'h05);
		repeat (4) @(negedge clk);
		chk_reg(8'(rs_cnt), 8'h01);
		i_tx_host_model.wr(OFS_SYNC_CTRL, 8'h04);
		i_tx_host_model.wr(OFS_SYNC_CTRL, 8'h05);
		repeat (4) @(negedge clk);
		chk_reg(8'(rs_cnt), 8'h02);

		// Frame hunt, then the summary bit drops once serviced
		frame_hunt_live = 1'b1;
		repeat (3) @(negedge clk);
		rdc(OFS_SYNC_LS, 8'h03);
		rdc(OFS_SUMMARY, 8'h04);
		frame_hunt_live = 1'b0;
		i_tx_host_model.wr(OFS_SYNC_LS, 8'h01);
		repeat (2) @(negedge clk);
		rdc(OFS_SYNC_LS, 8'h00);
		rdc(OFS_SUMMARY, 8'h00);

		// Each watermark: at the threshold is not below, one less is
		foreach (wm[s])
		begin
			fifo_level = FIFO_DEPTH;
			i_tx_host_model.wr(OFS_FIFO_CTRL, 8'(s));
			i_tx_host_model.wr(OFS_HDLC_LS, 8'hff);
			fifo_level = wm[s];
			repeat (3) @(negedge clk);
			rdc(OFS_HDLC_LS, 8'h01);
			fifo_level = wm[s] - 7'h01;
			repeat (3) @(negedge clk);
			rdc(OFS_HDLC_LS, 8'h03);
		end
		rdc(OFS_SUMMARY, 8'h02);

		// Set wins when an event meets a clear of its own bit
		fork
			i_tx_host_model.wr(OFS_MAIN_LS, 8'h04);
			begin
				@(negedge clk);
				mf_evt = 1'b1;
				@(negedge clk);
				mf_evt = 1'b0;
			end
		join
		rdc(OFS_MAIN_LS, 8'h04);
		i_tx_host_model.wr(OFS_MAIN_LS, 8'h04);

		// Reset in mid-run; FIFO full so no level edge follows release
		fifo_level = FIFO_DEPTH;
		srst = 1'b1;
		repeat (4) @(negedge clk);
		srst = 1'b0;
		foreach (rst_addr[i])
			rdc(rst_addr[i], RST_VAL);
		chk_bit(interrupt_out_n, 1'b1);
		chk_bit(sync_enable, 1'b0);
		wrap_up();
	end
endmodule
